// file: hw/long_mode_pkg.sv
`default_nettype none
package long_mode_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_FEATURE = 8'h00; // extended_feature_register
  localparam logic [7:0] OFS_CTRL0 = 8'h04;   // paging control
  localparam logic [7:0] OFS_CTRL4 = 8'h08;   // address extension control
  localparam logic [7:0] OFS_STATUS = 8'h0C;  // refusal flag and sub-mode
  localparam logic [7:0] OFS_FS_LO = 8'h10;
  localparam logic [7:0] OFS_FS_HI = 8'h14;
  localparam logic [7:0] OFS_GS_LO = 8'h18;
  localparam logic [7:0] OFS_GS_HI = 8'h1C;
  localparam logic [7:0] OFS_TSS_LO = 8'h20;
  localparam logic [7:0] OFS_TSS_HI = 8'h24;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ENABLE_POS = 8;   // long_regime_enable_bit
  localparam int ACTIVE_POS = 10;  // long_regime_active_flag
  localparam int PAGING_POS = 31;  // paging_enable_bit
  localparam int PAE_POS = 5;      // physical_address_extension
  localparam int REFUSED_POS = 0;  // sticky, write one to clear
  localparam int SUBMODE_LSB = 4;  // four bits of sub-mode

  // ****************************************
  // reset values and size codes
  // ****************************************
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [63:0] RESET_BASE = 64'h0000_0000_0000_0000;
  localparam logic [6:0] SIZE16 = 7'h10;
  localparam logic [6:0] SIZE32 = 7'h20;
  localparam logic [6:0] SIZE64 = 7'h40;
  localparam logic [2:0] LEVELS_2 = 3'h2;
  localparam logic [2:0] LEVELS_3 = 3'h3;
  localparam logic [2:0] LEVELS_4 = 3'h4;

  // task segment field selectors
  localparam logic [3:0] TSS_SEL_IST1 = 4'h3;
  localparam logic [3:0] TSS_SEL_IST7 = 4'h9;
  localparam logic [3:0] TSS_SEL_IOMAP = 4'hA;

  // operating sub-modes, one-hot
  typedef enum logic [3:0] {
    SUB_LEGACY = 4'b0001,
    SUB_64 = 4'b0010,
    SUB_COMPAT = 4'b0100,
    SUB_RESERVED = 4'b1000
  } submode_t;

endpackage
`default_nettype wire

// file: hw/sub_mode_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module sub_mode_decoder import long_mode_pkg::*;
(
  input wire logic activeFlag,
  input wire logic csLongAttr,
  input wire logic csDefaultAttr,
  output var submode_t subMode,
  output logic [6:0] addrSize,
  output logic [6:0] opSize
);

  // ****************************************
  // attribute decode
  // ****************************************
  // long attribute only counts once the regime is active
  wire logic isSub64 = activeFlag & csLongAttr & ~csDefaultAttr;
  wire logic isCompat = activeFlag & ~csLongAttr;
  // both attributes set is a reserved encoding
  wire logic isResvd = activeFlag & csLongAttr & csDefaultAttr;

  assign subMode = isSub64 ? SUB_64 :
                   isCompat ? SUB_COMPAT :
                   isResvd ? SUB_RESERVED : SUB_LEGACY;
  // address size: 64 only in 64-bit sub-mode
  assign addrSize = isSub64 ? SIZE64 : csDefaultAttr ? SIZE32 : SIZE16;
  // operand size stays 32 by default even in 64-bit sub-mode
  assign opSize = (isSub64 | csDefaultAttr) ? SIZE32 : SIZE16;

endmodule // sub_mode_decoder
`default_nettype wire

// file: hw/tss_field_locator.sv
`timescale 1ns/100ps
`default_nettype none
module tss_field_locator import long_mode_pkg::*;
#(
  parameter logic [15:0] STACK_OFS = 16'h0004, // first stack pointer
  parameter logic [15:0] IST_OFS = 16'h0024,   // first stack-table pointer
  parameter logic [15:0] IOMAP_OFS = 16'h0066, // redirection bitmap base
  parameter logic [15:0] SLOT = 16'h0008       // pointer slot size
)
(
  input wire logic [63:0] tssBase,
  input wire logic [3:0] fieldSel,
  output logic [63:0] fieldAddr,
  output logic fieldValid
);

  // ****************************************
  // field offset inside the single segment
  // ****************************************
  wire logic [15:0] selWide = {12'h000, fieldSel};
  wire logic [15:0] istIdx = {12'h000, fieldSel - TSS_SEL_IST1};
  wire logic [15:0] fieldOfs;

  // levels 0..2 first, then stack-table slots, then bitmap base
  assign fieldOfs = (fieldSel < TSS_SEL_IST1) ? STACK_OFS + SLOT * selWide :
                    (fieldSel <= TSS_SEL_IST7) ? IST_OFS + SLOT * istIdx :
                    IOMAP_OFS;
  assign fieldValid = fieldSel <= TSS_SEL_IOMAP;
  assign fieldAddr = tssBase + {48'h0000_0000_0000, fieldOfs};

endmodule // tss_field_locator
`default_nettype wire

// file: hw/long_regime_control.sv
`timescale 1ns/100ps
`default_nettype none
module long_regime_control import long_mode_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic csLongAttr,
  input wire logic csDefaultAttr,
  input wire logic intRequest,
  input wire logic taskSwitchRequest,
  input wire logic [3:0] tssFieldSel,
  output logic longRegimeActive,
  output logic pagingOn,
  output var submode_t subMode,
  output logic [6:0] addrSize,
  output logic [6:0] opSize,
  output logic intTake64,
  output logic intTakeLegacy,
  output logic dataSegsIgnored,
  output logic taskSwitchGo,
  output logic taskSwitchFault,
  output logic [2:0] translationLevels,
  output logic physAddrWide,
  output logic [63:0] fsBase,
  output logic [63:0] gsBase,
  output logic [63:0] tssFieldAddr,
  output logic tssFieldValid
);

  // ****************************************
  // state
  // ****************************************
  logic enableBit;    // long_regime_enable_bit
  logic activeFlag;   // long_regime_active_flag
  logic paeOn;        // physical_address_extension
  logic refusedFlag;  // sticky: a control write was refused
  logic [63:0] tssBase;
  logic [31:0] rdata;

  // ****************************************
  // bus decode
  // ****************************************
  wire logic access = cyc_i & stb_i;
  // writes land on the edge where the master sees ack
  wire logic wrStrobe = access & we_i & ack_o;
  wire logic hitFeature = adr_i == OFS_FEATURE;
  wire logic hitCtrl0 = adr_i == OFS_CTRL0;
  wire logic hitCtrl4 = adr_i == OFS_CTRL4;
  wire logic hitStatus = adr_i == OFS_STATUS;
  wire logic hitFsLo = adr_i == OFS_FS_LO;
  wire logic hitFsHi = adr_i == OFS_FS_HI;
  wire logic hitGsLo = adr_i == OFS_GS_LO;
  wire logic hitGsHi = adr_i == OFS_GS_HI;
  wire logic hitTssLo = adr_i == OFS_TSS_LO;
  wire logic hitTssHi = adr_i == OFS_TSS_HI;
  // byte-lane mask, one lane per select bit
  logic [31:0] laneMask;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gLane
      assign laneMask[8*g +: 8] = {8{sel_i[g]}};
    end
  endgenerate
  // single-bit fields only move when their lane is selected
  wire logic wrFeature = wrStrobe & hitFeature & sel_i[ENABLE_POS/8];
  wire logic wrCtrl0 = wrStrobe & hitCtrl0 & sel_i[PAGING_POS/8];
  wire logic wrCtrl4 = wrStrobe & hitCtrl4 & sel_i[PAE_POS/8];
  wire logic wrStatus = wrStrobe & hitStatus & sel_i[REFUSED_POS/8];
  wire logic pgReq = dat_i[PAGING_POS];
  // FS and GS upper base halves only load in 64-bit sub-mode
  wire logic inSub64 = subMode == SUB_64;
  // merge selected lanes into an old word
  function automatic logic [31:0] mergeWord(input logic [31:0] old,
                                           input logic [31:0] mask,
                                           input logic [31:0] data);
    mergeWord = (old & ~mask) | (data & mask);
  endfunction

  // ****************************************
  // control bit next values
  // ****************************************
  // activation without address extension is refused
  wire logic pgRefuse = wrCtrl0 & pgReq & ~pagingOn & enableBit & ~paeOn;
  // enable bit frozen while paging is on
  wire logic lmeRefuse = wrFeature & pagingOn &
                         (dat_i[ENABLE_POS] != enableBit);
  // extension may not drop under an active regime
  wire logic paeRefuse = wrCtrl4 & activeFlag & ~dat_i[PAE_POS];
  wire logic anyRefuse = pgRefuse | lmeRefuse | paeRefuse;
  wire logic pgTake = wrCtrl0 & ~pgRefuse;
  wire logic next_paging = pgTake ? pgReq : pagingOn;
  // paging on with enable set activates
  // paging off drops the active flag
  wire logic next_active = pgTake ? (pgReq & enableBit) : activeFlag;
  // the enable bit alone never activates
  wire logic next_enable = (wrFeature & ~lmeRefuse) ?
                           dat_i[ENABLE_POS] : enableBit;
  wire logic next_pae = (wrCtrl4 & ~paeRefuse) ? dat_i[PAE_POS] : paeOn;
  // set wins over a same-cycle clear
  wire logic next_refused = anyRefuse |
                    (refusedFlag & ~(wrStatus & dat_i[REFUSED_POS]));

  // ****************************************
  // control registers
  // ****************************************
  // short process: the control bit decisions live in the wires above
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      enableBit <= 1'b0;
      activeFlag <= 1'b0;
      pagingOn <= 1'b0;
      paeOn <= 1'b0;
      refusedFlag <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= RESET_WORD;
    end
    else
    begin
      enableBit <= next_enable;
      activeFlag <= next_active;
      pagingOn <= next_paging;
      paeOn <= next_pae;
      refusedFlag <= next_refused;
      // one wait state; ack drops the cycle after it was given
      ack_o <= access & ~ack_o;
      dat_o <= (access & ~ack_o & ~we_i) ? rdata : RESET_WORD;
    end
  end

  // ****************************************
  // segment and task segment bases
  // ****************************************
  // FS and GS upper halves load only in 64-bit sub-mode; the task segment upper half always loads
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      fsBase <= RESET_BASE;
      gsBase <= RESET_BASE;
      tssBase <= RESET_BASE;
    end
    else if (wrStrobe)
    begin
      if (hitFsLo)
        fsBase[31:0] <= mergeWord(fsBase[31:0], laneMask, dat_i);
      if (hitFsHi && inSub64)
        fsBase[63:32] <= mergeWord(fsBase[63:32], laneMask, dat_i);
      if (hitGsLo)
        gsBase[31:0] <= mergeWord(gsBase[31:0], laneMask, dat_i);
      if (hitGsHi && inSub64)
        gsBase[63:32] <= mergeWord(gsBase[63:32], laneMask, dat_i);
      if (hitTssLo)
        tssBase[31:0] <= mergeWord(tssBase[31:0], laneMask, dat_i);
      if (hitTssHi)
        tssBase[63:32] <= mergeWord(tssBase[63:32], laneMask, dat_i);
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // unmapped addresses read zero and still acknowledge
  always_comb
  begin
    rdata = RESET_WORD;
    if (hitFeature)
    begin
      rdata[ENABLE_POS] = enableBit;
      rdata[ACTIVE_POS] = activeFlag;
    end
    else if (hitCtrl0)
      rdata[PAGING_POS] = pagingOn;
    else if (hitCtrl4)
      rdata[PAE_POS] = paeOn;
    else if (hitStatus)
    begin
      rdata[REFUSED_POS] = refusedFlag;
      rdata[SUBMODE_LSB +: 4] = subMode;
    end
    else if (hitFsLo)
      rdata = fsBase[31:0];
    else if (hitFsHi)
      rdata = fsBase[63:32];
    else if (hitGsLo)
      rdata = gsBase[31:0];
    else if (hitGsHi)
      rdata = gsBase[63:32];
    else if (hitTssLo)
      rdata = tssBase[31:0];
    else if (hitTssHi)
      rdata = tssBase[63:32];
  end

  // ****************************************
  // mode decode and derived outputs
  // ****************************************
  submode_t decMode;
  logic [6:0] decAddr;
  logic [6:0] decOp;
  logic [63:0] locAddr;
  logic locValid;
  sub_mode_decoder uDecode (
    .activeFlag(activeFlag), .csLongAttr(csLongAttr),
    .csDefaultAttr(csDefaultAttr), .subMode(decMode),
    .addrSize(decAddr), .opSize(decOp)
  );
  tss_field_locator uTss (
    .tssBase(tssBase), .fieldSel(tssFieldSel),
    .fieldAddr(locAddr), .fieldValid(locValid)
  );
  // data outputs are registered, one cycle behind their cause
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      subMode <= SUB_LEGACY;
      addrSize <= SIZE32;
      opSize <= SIZE32;
      dataSegsIgnored <= 1'b0;
      translationLevels <= LEVELS_2;
      physAddrWide <= 1'b0;
      tssFieldAddr <= RESET_BASE;
      tssFieldValid <= 1'b0;
    end
    else
    begin
      subMode <= decMode;
      addrSize <= decAddr;
      opSize <= decOp;
      // data segments ignored in 64-bit sub-mode
      dataSegsIgnored <= decMode == SUB_64;
      translationLevels <= activeFlag ? LEVELS_4 :
                           paeOn ? LEVELS_3 : LEVELS_2;
      physAddrWide <= activeFlag;
      tssFieldAddr <= locAddr;
      tssFieldValid <= locValid & activeFlag;
    end
  end
  assign longRegimeActive = activeFlag;
  // interrupts go through 64-bit gates when active
  assign intTake64 = intRequest & activeFlag;
  assign intTakeLegacy = intRequest & ~activeFlag;
  // task switches fault instead of running when active
  assign taskSwitchGo = taskSwitchRequest & ~activeFlag;
  assign taskSwitchFault = taskSwitchRequest & activeFlag;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence sActivate;
    pgTake && pgReq && enableBit;
  endsequence
  sequence sDeactivate;
    pgTake && !pgReq && activeFlag;
  endsequence
  a_enable_only: assert property (
    wrFeature && !pagingOn && !activeFlag |=> !activeFlag)
    else $error("enable bit alone activated the regime");
  a_activate_paging: assert property (
    sActivate |=> activeFlag && pagingOn ##1 translationLevels == LEVELS_4)
    else $error("paging on with enable did not activate");
  a_legacy_sizes: assert property (
    !activeFlag |=> subMode == SUB_LEGACY && !physAddrWide)
    else $error("64-bit feature visible while inactive");
  a_refuse_enable: assert property (
    lmeRefuse |=> enableBit == $past(enableBit) && refusedFlag)
    else $error("enable changed with paging on");
  a_int_gate: assert property (
    intRequest |-> intTake64 == activeFlag && intTakeLegacy != activeFlag)
    else $error("interrupt taken in wrong width");
  a_seg_ignore: assert property (
    activeFlag && csLongAttr && !csDefaultAttr |=> dataSegsIgnored)
    else $error("data segments not ignored in 64-bit sub-mode");
  a_no_task_switch: assert property (
    taskSwitchRequest && activeFlag |-> taskSwitchFault && !taskSwitchGo)
    else $error("task switch allowed while active");
  a_four_level: assert property (
    activeFlag |-> paeOn ##1 translationLevels == LEVELS_4)
    else $error("active without extension or four levels");
  a_sub64_sizes: assert property (
    activeFlag && csLongAttr && !csDefaultAttr
      |=> addrSize == SIZE64 && opSize == SIZE32)
    else $error("64-bit sub-mode sizes wrong");
  a_compat_sizes: assert property (
    activeFlag && !csLongAttr && csDefaultAttr
      |=> subMode == SUB_COMPAT && addrSize == SIZE32 && opSize == SIZE32)
    else $error("compatibility sub-mode sizes wrong");
  a_tss_gate: assert property (
    !activeFlag |=> !tssFieldValid)
    else $error("segment field offered while inactive");
  a_base_high: assert property (
    wrStrobe && hitFsHi && !inSub64 |=> $stable(fsBase[63:32]))
    else $error("upper base loaded outside 64-bit sub-mode");
  a_paging_write: assert property (
    pgTake |=> pagingOn == $past(pgReq))
    else $error("paging bit did not follow write");
  a_paging_off: assert property (
    sDeactivate |=> !activeFlag && !pagingOn)
    else $error("paging off left regime active");
  a_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
endmodule // long_regime_control
`default_nettype wire

// file: test/long_regime_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module long_regime_control_bench import long_mode_pkg::*;
;
  // ****************************************
  // stimulus and observation signals
  // ****************************************
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] laneSel = 4'hF; // lanes for the next bus cycle
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic csLong = 1'b0;
  logic csDef = 1'b0;
  logic intReq = 1'b0;
  logic tsReq = 1'b0;
  logic [3:0] fieldSel = 4'h0;
  logic active, paging, intTake64, intTakeLegacy, segsIgnored;
  logic taskGo, taskFault, physWide, fieldValid;
  submode_t subMode;
  logic [6:0] addrSize, opSize;
  logic [2:0] levels;
  logic [63:0] fsBase, gsBase, fieldAddr;
  logic [31:0] rd;
  int bad_count = 0;
  int check_count = 0;

  // 100 ns period
  always #50 clock = ~clock;

  long_regime_control u_long_regime_control (
    .clock(clock), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .csLongAttr(csLong), .csDefaultAttr(csDef), .intRequest(intReq),
    .taskSwitchRequest(tsReq), .tssFieldSel(fieldSel),
    .longRegimeActive(active), .pagingOn(paging), .subMode(subMode),
    .addrSize(addrSize), .opSize(opSize), .intTake64(intTake64),
    .intTakeLegacy(intTakeLegacy), .dataSegsIgnored(segsIgnored),
    .taskSwitchGo(taskGo), .taskSwitchFault(taskFault),
    .translationLevels(levels), .physAddrWide(physWide),
    .fsBase(fsBase), .gsBase(gsBase), .tssFieldAddr(fieldAddr),
    .tssFieldValid(fieldValid)
  );

  // ****************************************
  // shared helpers
  // ****************************************
  // compare wide enough for any output; unknown never matches
  task automatic check(input string name, input logic [63:0] exp,
                       input logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= laneSel;
    wdat <= d;
    do
    begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50)
      check("ack wait", 64'h1, 64'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // core-side inputs change right after an edge
  task automatic core(input logic l, input logic d, input logic i,
                      input logic t);
    @(posedge clock);
    csLong <= l;
    csDef <= d;
    intReq <= i;
    tsReq <= t;
  endtask

  // registered outputs trail their causes by one or two edges
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check("active", 64'h0, active);
    check("subMode", SUB_LEGACY, subMode);
    check("addrSize", SIZE32, addrSize);
    check("levels", LEVELS_2, levels);
    wb(1'b0, 8'h30, 32'h0, rd);
    check("unmapped read", 64'h0, rd);
  endtask

  // enabled but not active: still plain legacy behaviour
  task automatic t_enable_only();
    wr(OFS_FEATURE, 32'h0000_0100);
    core(1'b1, 1'b0, 1'b1, 1'b1);
    settle();
    wb(1'b0, OFS_FEATURE, 32'h0, rd);
    check("feature", 64'h100, rd);
    check("active", 64'h0, active);
    check("subMode", SUB_LEGACY, subMode);
    check("segsIgnored", 64'h0, segsIgnored);
    check("intTakeLegacy", 64'h1, intTakeLegacy);
    check("taskGo", 64'h1, taskGo);
    core(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  // paging without address extension is turned away
  task automatic t_refused();
    wr(OFS_CTRL0, 32'h8000_0000);
    settle();
    check("paging", 64'h0, paging);
    check("active", 64'h0, active);
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    check("refused", 64'h1, rd[REFUSED_POS]);
    wr(OFS_STATUS, 32'h0000_0001);
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    check("refused clear", 64'h0, rd[REFUSED_POS]);
  endtask

  task automatic t_activate();
    wr(OFS_CTRL4, 32'h0000_0020);
    settle();
    check("levels", LEVELS_3, levels);
    wr(OFS_CTRL0, 32'h8000_0000);
    settle();
    check("paging", 64'h1, paging);
    check("active", 64'h1, active);
    check("levels", LEVELS_4, levels);
    check("physWide", 64'h1, physWide);
    wb(1'b0, OFS_FEATURE, 32'h0, rd);
    check("feature", 64'h500, rd);
    // enable and extension are frozen under an active regime
    wr(OFS_FEATURE, 32'h0000_0000);
    wr(OFS_CTRL4, 32'h0000_0000);
    settle();
    check("levels", LEVELS_4, levels);
    wb(1'b0, OFS_FEATURE, 32'h0, rd);
    check("feature", 64'h500, rd);
    wb(1'b0, OFS_CTRL4, 32'h0, rd);
    check("extension", 64'h20, rd);
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    check("refused", 64'h1, rd[REFUSED_POS]);
    wr(OFS_STATUS, 32'h0000_0001);
  endtask

  // code attributes pick the sub-mode; upper base halves only in 64-bit
  task automatic t_submodes();
    core(1'b1, 1'b0, 1'b1, 1'b1);
    settle();
    check("subMode", SUB_64, subMode);
    check("addrSize", SIZE64, addrSize);
    check("opSize", SIZE32, opSize);
    check("segsIgnored", 64'h1, segsIgnored);
    check("intTake64", 64'h1, intTake64);
    check("intTakeLegacy", 64'h0, intTakeLegacy);
    check("taskFault", 64'h1, taskFault);
    check("taskGo", 64'h0, taskGo);
    wr(OFS_FS_LO, 32'h89AB_CDEF);
    wr(OFS_FS_HI, 32'h0123_4567);
    wr(OFS_GS_HI, 32'hFEDC_BA98);
    wr(OFS_GS_LO, 32'h7654_3210);
    settle();
    check("fsBase", 64'h0123_4567_89AB_CDEF, fsBase);
    check("gsBase", 64'hFEDC_BA98_7654_3210, gsBase);
    core(1'b0, 1'b1, 1'b0, 1'b0);
    settle();
    check("subMode", SUB_COMPAT, subMode);
    check("addrSize", SIZE32, addrSize);
    check("opSize", SIZE32, opSize);
    check("segsIgnored", 64'h0, segsIgnored);
    wr(OFS_FS_HI, 32'h5555_AAAA);
    settle();
    check("fsBase", 64'h0123_4567_89AB_CDEF, fsBase);
    // only the selected byte lane merges into the base
    laneSel = 4'h1;
    wr(OFS_FS_LO, 32'h0000_0011);
    laneSel = 4'hF;
    settle();
    check("fsBase", 64'h0123_4567_89AB_CD11, fsBase);
    // default-size clear gives 16-bit sizes in compatibility
    core(1'b0, 1'b0, 1'b0, 1'b0);
    settle();
    check("subMode", SUB_COMPAT, subMode);
    check("addrSize", SIZE16, addrSize);
    check("opSize", SIZE16, opSize);
    // both attributes set is the reserved encoding
    core(1'b1, 1'b1, 1'b0, 1'b0);
    settle();
    check("subMode", SUB_RESERVED, subMode);
    check("segsIgnored", 64'h0, segsIgnored);
  endtask

  // every field selector of the single task segment
  task automatic t_task_segment();
    logic [63:0] base, ofs;
    base = 64'h0000_0001_0000_1000;
    wr(OFS_TSS_LO, base[31:0]);
    wr(OFS_TSS_HI, base[63:32]);
    for (int s = 0; s < 12; s++)
    begin
      if (s < 3)
        ofs = 64'h4 + 64'(8 * s);
      else if (s < 10)
        ofs = 64'h24 + 64'(8 * (s - 3));
      else
        ofs = 64'h66;
      @(posedge clock);
      fieldSel <= 4'(s);
      settle();
      check("fieldValid", (s < 11) ? 64'h1 : 64'h0, fieldValid);
      if (s < 11)
        check("fieldAddr", base + ofs, fieldAddr);
    end
  endtask

  // paging off leaves the extended regime
  task automatic t_deactivate();
    wr(OFS_CTRL0, 32'h0000_0000);
    settle();
    check("paging", 64'h0, paging);
    check("active", 64'h0, active);
    check("levels", LEVELS_3, levels);
    check("subMode", SUB_LEGACY, subMode);
    check("physWide", 64'h0, physWide);
  endtask

  // ****************************************
  // verdict and main sequence
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // generous span; the whole sequence needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    #1;
    t_reset();
    t_enable_only();
    t_refused();
    t_activate();
    t_submodes();
    t_task_segment();
    t_deactivate();
    tally_and_finish();
  end
endmodule // long_regime_control_bench
`default_nettype wire
